// ==== dbgsa_top.sv ====
// System access registers of the debug port, reached over AHB-Lite
//
// Function
// - Clock select 0..3 gives 32/16/8/4 MHz
// - Clock select resets to 3, 4 MHz
// - Writing one to commit starts flash programming
// - Commit write ignored without write key
// - Clock request keeps system clock running
// - Writing zero withdraws clock request
// - Interface enable sets clock request
// - Erase failure flag, cleared by bus reset or by a held reset
// - Reset active flag set by system reset, held until read
// - Reading status clears reset active flag
// - Sleep flag shows idle or deeper sleep
// - NVM ready flag; debugger resets afterwards
// - User row ready flag; debugger commits after
// - Lock flag resets one, clears after erase
// - Memory check status one-hot encoded
// - Signature 0x59 holds reset, 0x00 releases
`include "dbgsa_params.svh"

module dbgsa_top #(
   parameter int ADDR_W = 8
) (
   input  wire logic                 hclk,              // Bus clock, 100 MHz
   input  wire logic                 hresetn,           // Async reset, active low
   input  wire logic                 hsel,              // Slave select
   input  wire logic [31:0]          haddr,             // Byte address
   input  wire logic [1:0]           htrans,            // Transfer type
   input  wire logic                 hwrite,            // Write when high
   input  wire logic [2:0]           hsize,             // Transfer size
   input  wire logic [31:0]          hwdata,            // Write data
   input  wire logic                 hready,            // Bus ready in
   output logic [31:0]               hrdata,            // Read data
   output logic                      hreadyout,         // Slave ready
   output logic                      hresp,             // Always OKAY
   input  wire logic                 if_enable,         // Debug interface enabled
   input  wire logic                 user_row_write_key,// Write key decoded
   input  wire dbgsa_pkg::dbgsa_sys_s sys_in,           // System status inputs
   input  wire logic                 erase_fail_evt,    // Chip erase failed pulse
   output dbgsa_pkg::dbgsa_ctl_s     ctl_out            // Controls to system
);
   import dbgsa_pkg::*;

   // Address phase capture
   logic             wr_pend_q, wr_pend_d;
   logic             rd_pend_q, rd_pend_d;
   logic [ADDR_W-1:0] idx_q, idx_d;

   // Register state
   logic [1:0] clksel_q, clksel_d;
   logic       system_clock_request_q, system_clock_request_d;
   logic       commit_q, commit_d;
   logic [7:0] rstreq_q, rstreq_d;
   logic       efail_q, efail_d;
   logic       system_reset_active_flag_q, system_reset_active_flag_d;
   logic       en_prev_q, en_prev_d;
   logic [31:0] hrdata_q, hrdata_d;
   dbgsa_ctl_s ctl_q, ctl_d;
   logic       hreadyout_q, hreadyout_d;
   logic       hresp_q, hresp_d;

   logic        addr_ok;
   logic        wr_clksel;
   logic        wr_sysctrl;
   logic        wr_rstreq;
   logic        rd_sysstat;
   logic [7:0]  stat_byte;

   function automatic logic [7:0] status_byte(input dbgsa_sys_s s, input logic ef,
                                              input logic sr);
      logic [7:0] b;
      b = 8'h00;
      b[`DBGSA_BIT_ERASE_FAILED_FLAG] = ef;
      b[`DBGSA_BIT_SYSTEM_RESET_ACTIVE_FLAG]    = sr;
      b[`DBGSA_BIT_SLEEP]     = s.sleeping;
      b[`DBGSA_BIT_NVM_PROGRAMMING_READY_FLAG]   = s.nvm_ready;
      b[`DBGSA_BIT_USER_ROW_PROGRAMMING_READY_FLAG]  = s.urow_ready;
      b[`DBGSA_BIT_LOCK]      = s.locked;
      return b;
   endfunction

   // Address phase decode and data phase strobes
   always_comb begin
      // Only whole-word NONSEQ or SEQ transfers reach the registers
      addr_ok   = hsel && hready && hsize == `DBGSA_HSIZE_WORD
                  && (htrans == `DBGSA_HTRANS_NONSEQ || htrans == `DBGSA_HTRANS_SEQ);
      wr_pend_d = addr_ok && hwrite;
      rd_pend_d = addr_ok && !hwrite;
      idx_d     = addr_ok ? haddr[ADDR_W+`DBGSA_ADDR_LSB-1:`DBGSA_ADDR_LSB] : idx_q;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         idx_q     <= '0;
      end else begin
         wr_pend_q <= wr_pend_d;
         rd_pend_q <= rd_pend_d;
         idx_q     <= idx_d;
      end
   end

   always_comb begin
      wr_clksel  = 1'b0;
      wr_sysctrl = 1'b0;
      wr_rstreq  = 1'b0;
      if (wr_pend_q && idx_q == ADDR_W'(`DBGSA_IDX_CLKSEL)) begin
         wr_clksel = 1'b1;
      end else if (wr_pend_q && idx_q == ADDR_W'(`DBGSA_IDX_SYSCTRL)) begin
         wr_sysctrl = 1'b1;
      end else if (wr_pend_q && idx_q == ADDR_W'(`DBGSA_IDX_RSTREQ)) begin
         wr_rstreq = 1'b1;
      end
      rd_sysstat = rd_pend_d && haddr[ADDR_W+`DBGSA_ADDR_LSB-1:`DBGSA_ADDR_LSB]
                   == ADDR_W'(`DBGSA_IDX_SYSSTAT);
   end

   // Clock select group
   // Enable edge wins over a write in the same cycle
   always_comb begin
      clksel_d = clksel_q;
      if (wr_clksel) begin
         clksel_d = hwdata[1:0];
      end
      if (if_enable && !en_prev_q) begin
         clksel_d = `DBGSA_CLKSEL_RST;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clksel_q <= `DBGSA_CLKSEL_RST;
      end else begin
         clksel_q <= clksel_d;
      end
   end

   // Clock request group
   // Drops only on bus reset or when written with zero
   always_comb begin
      system_clock_request_d = system_clock_request_q;
      if (wr_sysctrl) begin
         system_clock_request_d = hwdata[`DBGSA_BIT_SYSTEM_CLOCK_REQUEST];
      end
      if (if_enable && !en_prev_q) begin
         system_clock_request_d = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         system_clock_request_q <= 1'b0;
      end else begin
         system_clock_request_q <= system_clock_request_d;
      end
   end

   // Enable edge tracker
   // A level held through reset still counts as an enable
   always_comb begin
      en_prev_d = if_enable;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         en_prev_q <= 1'b0;
      end else begin
         en_prev_q <= en_prev_d;
      end
   end

   // Commit pulse group, one cycle wide
   // Key is sampled in the data phase, with the write data
   always_comb begin
      commit_d = 1'b0;
      if (wr_sysctrl && hwdata[`DBGSA_BIT_USER_ROW_COMMIT_TRIGGER] && user_row_write_key) begin
         commit_d = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         commit_q <= 1'b0;
      end else begin
         commit_q <= commit_d;
      end
   end

   // Reset request group
   // Any other value is stored but leaves the system running
   always_comb begin
      rstreq_d = rstreq_q;
      if (wr_rstreq) begin
         rstreq_d = hwdata[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rstreq_q <= `DBGSA_RST_RUN;
      end else begin
         rstreq_q <= rstreq_d;
      end
   end

   // Erase failure flag group
   // A held reset clears the flag each cycle it stands
   always_comb begin
      efail_d = efail_q;
      // cleared by held reset, set wins
      if (rstreq_q == `DBGSA_RST_SIG) begin
         efail_d = 1'b0;
      end
      if (erase_fail_evt) begin
         efail_d = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         efail_q <= 1'b0;
      end else begin
         efail_q <= efail_d;
      end
   end

   // System reset flag group
   // Read clears in the address phase; the data phase shows the old value
   always_comb begin
      system_reset_active_flag_d = system_reset_active_flag_q;
      if (rd_sysstat) begin
         system_reset_active_flag_d = 1'b0;
      end
      if (sys_in.sys_reset_active
          || rstreq_q == `DBGSA_RST_SIG) begin
         system_reset_active_flag_d = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         system_reset_active_flag_q <= 1'b0;
      end else begin
         system_reset_active_flag_q <= system_reset_active_flag_d;
      end
   end

   // Word index match for the read decoder
   // Codes are byte-wide constants, cut to the index width
   function automatic logic reg_hit(input logic [ADDR_W-1:0] idx, input logic [7:0] code);
      return idx == ADDR_W'(code);
   endfunction

   // Read data group
   // Registered at the address edge so it stands in the data phase
   always_comb begin
      stat_byte = status_byte(sys_in, efail_q, system_reset_active_flag_q);
      hrdata_d  = 32'h0000_0000;
      if (rd_pend_d) begin
         if (reg_hit(idx_d, `DBGSA_IDX_CLKSEL)) begin
            hrdata_d = {30'h0, clksel_q};
         end else if (reg_hit(idx_d, `DBGSA_IDX_SYSCTRL)) begin
            // No readback: the commit bit always reads zero
            hrdata_d = {31'h0, system_clock_request_q};
         end else if (reg_hit(idx_d, `DBGSA_IDX_SYSSTAT)) begin
            hrdata_d = {24'h0, stat_byte};
         end else if (reg_hit(idx_d, `DBGSA_IDX_CRCSTAT)) begin
            hrdata_d = {29'h0, sys_in.crc_status};
         end else if (reg_hit(idx_d, `DBGSA_IDX_RSTREQ)) begin
            hrdata_d = {24'h0, rstreq_q};
         end
      end
   end

   // Drops back to zero after the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
      end else begin
         hrdata_q <= hrdata_d;
      end
   end

   // Bus response group
   // Zero wait states and always OKAY, held in flops so the outputs are registered
   always_comb begin
      hreadyout_d = 1'b1;
      hresp_d     = 1'b0;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
      end else begin
         hreadyout_q <= hreadyout_d;
         hresp_q     <= hresp_d;
      end
   end

   // Control output group
   // Registered copies of the next values, so every control is a flop output
   always_comb begin
      ctl_d.clk_sel        = clksel_d;
      ctl_d.clk_request    = system_clock_request_d;
      ctl_d.urow_commit    = commit_d;
      ctl_d.sys_reset_hold = (rstreq_d == `DBGSA_RST_SIG);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctl_q.clk_sel        <= `DBGSA_CLKSEL_RST;
         ctl_q.clk_request    <= 1'b0;
         ctl_q.urow_commit    <= 1'b0;
         ctl_q.sys_reset_hold <= 1'b0;
      end else begin
         ctl_q <= ctl_d;
      end
   end

   // Outputs straight from flops
   assign hrdata    = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp     = hresp_q;
   assign ctl_out   = ctl_q;

endmodule

// ==== dbgsa_params.svh ====
// Register map, reset values and field positions of the system access block
`ifndef DBGSA_PARAMS_SVH
`define DBGSA_PARAMS_SVH

`define DBGSA_IDX_CLKSEL     8'h09
`define DBGSA_IDX_SYSCTRL    8'h0A
`define DBGSA_IDX_SYSSTAT    8'h0B
`define DBGSA_IDX_CRCSTAT    8'h0C
`define DBGSA_IDX_RSTREQ     8'h08

`define DBGSA_CLKSEL_RST     2'h3
`define DBGSA_RST_SIG        8'h59
`define DBGSA_RST_RUN        8'h00

`define DBGSA_BIT_SYSTEM_CLOCK_REQUEST     0
`define DBGSA_BIT_USER_ROW_COMMIT_TRIGGER   1
`define DBGSA_BIT_LOCK       0
`define DBGSA_BIT_USER_ROW_PROGRAMMING_READY_FLAG   2
`define DBGSA_BIT_NVM_PROGRAMMING_READY_FLAG    3
`define DBGSA_BIT_SLEEP      4
`define DBGSA_BIT_SYSTEM_RESET_ACTIVE_FLAG     5
`define DBGSA_BIT_ERASE_FAILED_FLAG  6

`define DBGSA_CRC_OFF        3'h0
`define DBGSA_CRC_BUSY       3'h1
`define DBGSA_CRC_PASS       3'h2
`define DBGSA_CRC_FAIL       3'h4

`define DBGSA_HTRANS_NONSEQ  2'h2
`define DBGSA_HTRANS_SEQ     2'h3
`define DBGSA_HSIZE_WORD     3'h2
`define DBGSA_ADDR_LSB       2

`endif

// ==== dbgsa_pkg.sv ====
// Types shared by the system access block
package dbgsa_pkg;
   typedef struct packed {
      logic       erase_failed;
      logic       sys_reset_active;
      logic       sleeping;
      logic       nvm_ready;
      logic       urow_ready;
      logic       locked;
      logic [2:0] crc_status;
   } dbgsa_sys_s;

   typedef struct packed {
      logic [1:0] clk_sel;
      logic       clk_request;
      logic       urow_commit;
      logic       sys_reset_hold;
   } dbgsa_ctl_s;

   typedef enum logic [1:0] {DBGSA_IDLE, DBGSA_DATA} dbgsa_bus_e;
endpackage

// ==== dbgsa_top_properties.sv ====
// Port-level properties of the system access block
module dbgsa_top_properties
   import dbgsa_pkg::*;
(
   input wire logic        hclk,               // Clock
   input wire logic        hresetn,            // Reset
   input wire logic        hsel,               // Select
   input wire logic [31:0] haddr,              // Address
   input wire logic [1:0]  htrans,             // Transfer
   input wire logic        hwrite,             // Write
   input wire logic [31:0] hrdata,             // Read data
   input wire logic        hreadyout,          // Ready
   input wire logic        hresp,              // Response
   input wire logic        if_enable,          // Enable
   input wire logic        user_row_write_key, // Key
   input wire dbgsa_sys_s  sys_in,             // Status in
   input wire dbgsa_ctl_s  ctl_out             // Controls
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire acc = hsel && htrans[1] && hreadyout;
   wire rd_st = acc && !hwrite && haddr[7:0] == 8'h2C;
   property p_okay; hreadyout && !hresp && hrdata[31:8] == 24'h0; endproperty
   a_okay: assert property (p_okay) else $error("bad response");
   property p_enable; $rose(if_enable) |=> ctl_out.clk_request && ctl_out.clk_sel == 2'h3; endproperty
   a_enable: assert property (p_enable) else $error("enable not applied");
   property p_key; ctl_out.urow_commit |-> $past(user_row_write_key); endproperty
   a_key: assert property (p_key) else $error("commit without key");
   property p_pulse; ctl_out.urow_commit |=> !ctl_out.urow_commit; endproperty
   a_pulse: assert property (p_pulse) else $error("commit too long");
   property p_clksel; $changed(ctl_out.clk_sel) |-> $past(acc && hwrite, 2) || $past(if_enable);
   endproperty
   a_clksel: assert property (p_clksel) else $error("clock select moved");
   property p_crc; $past(acc && !hwrite && haddr[7:0] == 8'h30)
      |-> hrdata[7:0] == {5'h0, $past(sys_in.crc_status)}; endproperty
   a_crc: assert property (p_crc) else $error("check status wrong");
   property p_stat; $past(rd_st)
      |-> hrdata[4:2] == $past({sys_in.sleeping, sys_in.nvm_ready, sys_in.urow_ready}); endproperty
   a_stat: assert property (p_stat) else $error("status bits wrong");
   property p_lock; $past(rd_st) |-> hrdata[1:0] == {1'h0, $past(sys_in.locked)}; endproperty
   a_lock: assert property (p_lock) else $error("lock bit wrong");
   property p_hold; $rose(ctl_out.sys_reset_hold) |-> $past(acc && hwrite && haddr[7:0] == 8'h20, 2);
   endproperty
   a_hold: assert property (p_hold) else $error("reset hold uncaused");
endmodule

bind dbgsa_top dbgsa_top_properties chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
   .hrdata, .hreadyout, .hresp, .if_enable, .user_row_write_key, .sys_in, .ctl_out);

// ==== dbgsa_sys_model.sv ====
// System-domain model behind the system access block
module dbgsa_sys_model
   import dbgsa_pkg::*;
(
   input  wire dbgsa_ctl_s ctl, // Controls from block
   input  wire dbgsa_sys_s st,  // Scenario status
   output dbgsa_sys_s      sys  // Status to block
);
   always_comb begin
      sys = st;
      sys.sys_reset_active = ctl.sys_reset_hold;
   end
endmodule

// ==== debug_port_system_access_regs_test.sv ====
// Self-checking bench for the system access block
module debug_port_system_access_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   import dbgsa_pkg::*;
   typedef struct {logic w; logic [7:0] a, d; logic [8:0] s; logic [7:0] e;} dbgsa_row_s;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, if_enable = 0, key = 0, efail = 0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
   logic [1:0]  htrans = '0;
   logic [2:0]  hsize = 3'h2;
   logic        hreadyout, hresp, rdy;
   dbgsa_sys_s  st = '0, sys;
   dbgsa_ctl_s  ctl;
   int          n_errors = 0, tests_run = 0, commits = 0;
   dbgsa_row_s  rows[14] = '{
      '{1'h1, 8'h24, 8'h00, 9'h000, 8'h00}, '{1'h1, 8'h24, 8'h01, 9'h000, 8'h01},
      '{1'h1, 8'h24, 8'h02, 9'h000, 8'h02}, '{1'h1, 8'h24, 8'h03, 9'h000, 8'h03},
      '{1'h0, 8'h30, 8'h00, 9'h000, 8'h00}, '{1'h0, 8'h30, 8'h00, 9'h001, 8'h01},
      '{1'h0, 8'h30, 8'h00, 9'h002, 8'h02}, '{1'h0, 8'h30, 8'h00, 9'h004, 8'h04},
      '{1'h0, 8'h2C, 8'h00, 9'h008, 8'h01}, '{1'h0, 8'h2C, 8'h00, 9'h040, 8'h10},
      '{1'h0, 8'h2C, 8'h00, 9'h020, 8'h08}, '{1'h0, 8'h2C, 8'h00, 9'h010, 8'h04},
      '{1'h0, 8'h2C, 8'h00, 9'h000, 8'h00}, '{1'h0, 8'h34, 8'h00, 9'h000, 8'h00}};
   dbgsa_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .if_enable, .user_row_write_key(key),
      .sys_in(sys), .erase_fail_evt(efail), .ctl_out(ctl));
   dbgsa_sys_model sysm (.ctl, .st, .sys);
   always #5 hclk = ~hclk;
   always @(negedge hclk) if (ctl.urow_commit === 1'h1) commits++;
   task automatic chk(input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("tests_run %0d n_errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic bus_wait;
      int n;
      n = 0;
      do begin
         @(negedge hclk);
         q = hrdata;
         rdy = hreadyout;
         n++;
         @(posedge hclk);
      end while (rdy !== 1'h1 && n < 20);
      if (rdy !== 1'h1) begin
         n_errors++;
         results();
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, d);
      @(posedge hclk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      bus_wait();
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      bus_wait();
      @(negedge hclk);
   endtask
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'h1;
      @(negedge hclk);
      chk(ctl, 5'h18);
      xfer(1'h0, 8'h24, 8'h00);
      chk(q, 32'h3);
      $display("reset test done");
      foreach (rows[i]) begin
         st <= rows[i].s;
         xfer(rows[i].w, rows[i].a, rows[i].d);
         if (rows[i].w) chk(ctl.clk_sel, rows[i].e);
         else chk(q, rows[i].e);
      end
      $display("table test done");
      xfer(1'h1, 8'h24, 8'h00);
      @(posedge hclk);
      if_enable <= 1'h1;
      repeat (2) @(negedge hclk);
      chk({ctl.clk_sel, ctl.clk_request}, 3'h7);
      xfer(1'h1, 8'h28, 8'h00);
      chk(ctl.clk_request, 1'h0);
      xfer(1'h1, 8'h28, 8'h01);
      xfer(1'h0, 8'h28, 8'h00);
      chk({q, ctl.clk_request}, 33'h3);
      $display("clock request test done");
      st <= 9'h010;
      xfer(1'h1, 8'h28, 8'h03);
      repeat (2) @(negedge hclk);
      chk(commits, 0);
      @(posedge hclk);
      key <= 1'h1;
      // data in RAM once ready is seen
      xfer(1'h1, 8'h28, 8'h03);
      repeat (2) @(negedge hclk);
      chk(commits, 1);
      $display("commit test done");
      st <= '0;
      @(posedge hclk);
      efail <= 1'h1;
      @(posedge hclk);
      efail <= 1'h0;
      xfer(1'h0, 8'h2C, 8'h00);
      chk(q, 32'h40);
      xfer(1'h1, 8'h20, 8'h59);
      xfer(1'h0, 8'h2C, 8'h00);
      chk({q, ctl.sys_reset_hold}, 33'h41);
      xfer(1'h1, 8'h20, 8'h00);
      xfer(1'h0, 8'h2C, 8'h00);
      xfer(1'h0, 8'h2C, 8'h00);
      chk({q, ctl.sys_reset_hold}, 33'h0);
      $display("reset request test done");
      @(posedge hclk);
      efail <= 1'h1;
      @(posedge hclk);
      efail <= 1'h0;
      xfer(1'h0, 8'h2C, 8'h00);
      chk(q, 32'h40);
      @(posedge hclk);
      hresetn <= 1'h0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'h1;
      @(negedge hclk);
      chk(ctl, 5'h18);
      xfer(1'h0, 8'h2C, 8'h00);
      chk(q, 32'h0);
      $display("mid-run reset test done");
      results();
   end
endmodule
